// [embt_pkg.sv]
// constants, types and register map of the external memory bus sequencer
package embt_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int XD_W = 16;
	localparam int NBLK = 4;
	localparam int BLK_W = 2;
	localparam int CNT_W = 4;
	localparam int PADDR_W = 8;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [PADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [PADDR_W-1:0] OFF_BLK0 = 8'h10;
	localparam logic [PADDR_W-1:0] OFF_STEP = 8'h04;

	// control register fields (system_control_reg_three and port3_function_reg bits)
	localparam int CTRL_ASW = 0;
	localparam int CTRL_BE = 1;
	localparam int CTRL_STALLFN = 2;
	localparam int CTRL_MUX = 3;
	localparam logic [3:0] CTRL_RST = 4'h1;

	// block_wait_cfg and recovery fields of each block_pair_cs_config word
	localparam int BLK_AW_LSB = 0;
	localparam int BLK_XW = 3;
	localparam int BLK_W16 = 4;
	localparam int BLK_RRC_LSB = 5;
	localparam int BLK_WRC_LSB = 7;
	localparam int BLK_CSR = 9;
	localparam int BLK_CFG_W = 10;
	localparam logic [BLK_CFG_W-1:0] BLK_RST = 10'h000;

	// ==========================================================
	// timing in system clocks
	localparam logic [CNT_W-1:0] BUS_MIN_CLK = 4'h3;
	localparam logic [CNT_W-1:0] XWAIT_MIN = 4'h2;
	localparam logic [CNT_W-1:0] XWAIT_STEP = 4'h2;
	localparam logic [CNT_W-1:0] ASW_LONG = 4'h2;
	localparam logic [CNT_W-1:0] ASW_SHORT = 4'h1;
	localparam logic [1:0] RCV_MAX = 2'h2;

	// access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_STRB = 3'b010,
		ST_RECOV = 3'b011
	} embt_state_t;

	typedef struct packed {
		logic internal;
		logic write;
		logic [1:0] size;
		logic [BLK_W-1:0] blk;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} embt_req_t;

	typedef struct packed {
		logic csr;
		logic [1:0] wrc;
		logic [1:0] rrc;
		logic w16;
		logic xw;
		logic [2:0] aw;
	} embt_blk_cfg_t;

endpackage : embt_pkg

// [embt_seq.sv]
// external memory bus cycle sequencer with apb configuration registers
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module embt_seq
	import embt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [embt_pkg::PADDR_W-1:0] paddr,
	input wire logic [embt_pkg::DATA_W-1:0] pwdata,
	output logic [embt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire embt_pkg::embt_req_t req,
	output logic req_done,
	output logic [embt_pkg::DATA_W-1:0] req_rdata,
	input wire logic bus_mode_strap,
	input wire logic stall_pin,
	output logic [embt_pkg::ADDR_W-1:0] addr_out,
	output logic [embt_pkg::XD_W-1:0] data_out,
	output logic data_oe,
	input wire logic [embt_pkg::XD_W-1:0] data_in,
	output logic rd_n,
	output logic wr_n,
	output logic ale
);
	import embt_pkg::*;

	// ==========================================================
	// lane steering
	function automatic logic [XD_W-1:0] lane_out(logic [DATA_W-1:0] v, logic [1:0] sz,
		logic [1:0] beat, logic w16, logic be, logic a0);
		logic [1:0] last;
		logic [1:0] bidx;
		logic [XD_W-1:0] r;
		last = 2'((3'h1 << sz) - 3'h1);
		bidx = be ? 2'(last - beat) : beat;
		r = '0;
		if (w16)
		begin
			if (sz == SZ_WORD)
				r = (be ^ beat[0]) ? v[31:16] : v[15:0];
			else if (sz == SZ_HALF)
				r = v[15:0];
			else
				r = {v[7:0], v[7:0]};
		end
		else
			r = {8'h00, v[8*bidx +: 8]};
		return r;
	endfunction : lane_out

	function automatic logic [DATA_W-1:0] lane_in(logic [DATA_W-1:0] acc, logic [XD_W-1:0] d,
		logic [1:0] sz, logic [1:0] beat, logic w16, logic be, logic a0);
		logic [1:0] last;
		logic [1:0] bidx;
		logic [DATA_W-1:0] r;
		last = 2'((3'h1 << sz) - 3'h1);
		bidx = be ? 2'(last - beat) : beat;
		r = acc;
		if (w16)
		begin
			if (sz == SZ_WORD)
				r[16*(be ^ beat[0]) +: 16] = d;
			else if (sz == SZ_HALF)
				r[15:0] = d;
			else
				r[7:0] = (be ^ a0) ? d[15:8] : d[7:0];
		end
		else
			r[8*bidx +: 8] = d[7:0];
		return r;
	endfunction : lane_in

	// ==========================================================
	// configuration registers
	logic asw_sel_reg;
	logic big_end_reg;
	logic stall_fn_reg;
	logic mux_mode_reg;
	logic strap_taken_reg;
	embt_blk_cfg_t blk_cfg_reg [NBLK];
	logic apb_wr;
	logic apb_rd;
	logic [NBLK-1:0] blk_hit;
	logic [DATA_W-1:0] rd_val;
	logic rd_ok;
	embt_state_t state_reg;

	assign apb_wr = psel && penable && pready && pwrite;
	assign apb_rd = psel && penable && !pready;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			asw_sel_reg <= CTRL_RST[CTRL_ASW];
			big_end_reg <= CTRL_RST[CTRL_BE];
			stall_fn_reg <= CTRL_RST[CTRL_STALLFN];
		end
		else if (apb_wr && paddr == OFF_CTRL)
		begin
			asw_sel_reg <= pwdata[CTRL_ASW];
			big_end_reg <= pwdata[CTRL_BE];
			stall_fn_reg <= pwdata[CTRL_STALLFN];
		end
	end

	// mode strap caught after reset release
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			strap_taken_reg <= 1'b0;
			mux_mode_reg <= CTRL_RST[CTRL_MUX];
		end
		else if (!strap_taken_reg)
		begin
			strap_taken_reg <= 1'b1;
			mux_mode_reg <= bus_mode_strap;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NBLK; gi++)
		begin : g_blk
			assign blk_hit[gi] = (paddr == PADDR_W'(OFF_BLK0 + OFF_STEP * gi));
			// wait count and enable per block
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					blk_cfg_reg[gi] <= BLK_RST;
				else if (apb_wr && blk_hit[gi])
					blk_cfg_reg[gi] <= pwdata[BLK_CFG_W-1:0];
			end
		end
	endgenerate

	always_comb
	begin
		rd_val = '0;
		rd_ok = 1'b1;
		if (paddr == OFF_CTRL)
		begin
			rd_val[CTRL_ASW] = asw_sel_reg;
			rd_val[CTRL_BE] = big_end_reg;
			rd_val[CTRL_STALLFN] = stall_fn_reg;
			rd_val[CTRL_MUX] = mux_mode_reg;
		end
		else if (paddr == OFF_STAT)
			rd_val[2:0] = state_reg;
		else if (|blk_hit)
		begin
			for (int i = 0; i < NBLK; i++)
				if (blk_hit[i])
					rd_val[BLK_CFG_W-1:0] = blk_cfg_reg[i];
		end
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			if (apb_rd)
			begin
				pslverr <= !rd_ok;
				prdata <= pwrite ? '0 : rd_val;
			end
		end
	end

	// ==========================================================
	// bus cycle sequencer
	embt_req_t cur_reg;
	embt_blk_cfg_t cfg;
	logic [CNT_W-1:0] cnt_reg;
	logic [1:0] beat_reg;
	logic [1:0] last_beat;
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] acc_next;
	logic stall_req;
	logic [CNT_W-1:0] asw_clk;
	logic [CNT_W-1:0] aw_eff;
	logic [CNT_W-1:0] strb_len;
	logic [CNT_W-1:0] rec_len;
	logic [1:0] rcv;
	logic [ADDR_W-1:0] beat_addr;
	logic [ADDR_W-1:0] next_addr;
	logic [XD_W-1:0] beat_data;
	logic strb_end;

	// ready level inverted into stall request
	assign stall_req = stall_fn_reg ? !stall_pin : stall_pin;
	assign cfg = blk_cfg_reg[cur_reg.blk];
	assign asw_clk = asw_sel_reg ? ASW_LONG : ASW_SHORT;
	assign aw_eff = (cfg.xw && CNT_W'(cfg.aw) < XWAIT_MIN) ? XWAIT_MIN : CNT_W'(cfg.aw);
	// strobe part fills the three-clock minimum
	assign strb_len = BUS_MIN_CLK - asw_clk + aw_eff;
	assign rcv = cur_reg.write ? cfg.wrc : cfg.rrc;
	assign rec_len = CNT_W'((rcv > RCV_MAX) ? RCV_MAX : rcv) + CNT_W'(cfg.csr);
	assign last_beat = cfg.w16 ? ((cur_reg.size == SZ_WORD) ? 2'h1 : 2'h0)
		: 2'((3'h1 << cur_reg.size) - 3'h1);
	assign beat_addr = cfg.w16 ? cur_reg.addr + ADDR_W'({beat_reg, 1'b0})
		: cur_reg.addr + ADDR_W'(beat_reg);
	assign next_addr = cfg.w16 ? cur_reg.addr + ADDR_W'({beat_reg + 2'h1, 1'b0})
		: cur_reg.addr + ADDR_W'(beat_reg + 2'h1);
	assign beat_data = lane_out(cur_reg.wdata, cur_reg.size, beat_reg, cfg.w16,
		big_end_reg, cur_reg.addr[0]);
	assign acc_next = lane_in(acc_reg, data_in, cur_reg.size, beat_reg, cfg.w16,
		big_end_reg, cur_reg.addr[0]);
	assign strb_end = state_reg == ST_STRB && cnt_reg == '0 && !(cfg.xw && stall_req);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			cnt_reg <= '0;
			beat_reg <= '0;
			acc_reg <= '0;
			req_done <= 1'b0;
			req_rdata <= '0;
			addr_out <= '0;
			data_out <= '0;
			data_oe <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			ale <= 1'b0;
		end
		else
		begin
			req_done <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (req_valid && !req_done && strap_taken_reg)
					begin
						// no latch pulse for internal access
						if (req.internal)
						begin
							req_done <= 1'b1;
							req_rdata <= '0;
						end
						else
						begin
							cur_reg <= req;
							beat_reg <= '0;
							acc_reg <= '0;
							addr_out <= req.addr;
							cnt_reg <= asw_clk - 1'b1;
							state_reg <= ST_ADDR;
							// latch strobe only in multiplexed mode
							ale <= mux_mode_reg;
							data_oe <= mux_mode_reg || req.write;
							data_out <= mux_mode_reg ? req.addr[XD_W-1:0] : '0;
						end
					end
				end
				ST_ADDR:
				begin
					// strobe after two clocks when select set
					// strobe after one clock when select clear
					if (cnt_reg == '0)
					begin
						ale <= 1'b0;
						rd_n <= cur_reg.write;
						wr_n <= !cur_reg.write;
						data_oe <= cur_reg.write;
						data_out <= cur_reg.write ? beat_data : '0;
						cnt_reg <= strb_len - 1'b1;
						state_reg <= ST_STRB;
					end
					else
					begin
						cnt_reg <= cnt_reg - 1'b1;
						if (!mux_mode_reg && cur_reg.write)
							data_out <= beat_data;
					end
				end
				ST_STRB:
				begin
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					// external stall adds two clocks per sample
					else if (cfg.xw && stall_req)
						cnt_reg <= XWAIT_STEP - 1'b1;
					else
					begin
						rd_n <= 1'b1;
						wr_n <= 1'b1;
						data_oe <= 1'b0;
						acc_reg <= cur_reg.write ? acc_reg : acc_next;
						if (rec_len != '0)
						begin
							cnt_reg <= rec_len - 1'b1;
							state_reg <= ST_RECOV;
						end
						else if (beat_reg != last_beat)
						begin
							beat_reg <= beat_reg + 2'h1;
							addr_out <= next_addr;
							cnt_reg <= asw_clk - 1'b1;
							ale <= mux_mode_reg;
							data_oe <= mux_mode_reg;
							data_out <= mux_mode_reg ? next_addr[XD_W-1:0] : '0;
							state_reg <= ST_ADDR;
						end
						else
						begin
							req_done <= 1'b1;
							req_rdata <= cur_reg.write ? '0 : acc_next;
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_RECOV:
				begin
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else if (beat_reg != last_beat)
					begin
						beat_reg <= beat_reg + 2'h1;
						addr_out <= next_addr;
						cnt_reg <= asw_clk - 1'b1;
						ale <= mux_mode_reg;
						data_oe <= mux_mode_reg || cur_reg.write;
						data_out <= mux_mode_reg ? next_addr[XD_W-1:0] : '0;
						state_reg <= ST_ADDR;
					end
					else
					begin
						req_done <= 1'b1;
						req_rdata <= acc_reg;
						state_reg <= ST_IDLE;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// checks
	logic strobe_on;
	logic [CNT_W+1:0] cyc_len_reg;
	logic [CNT_W+1:0] strb_cnt_reg;
	assign strobe_on = !rd_n || !wr_n;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cyc_len_reg <= '0;
			strb_cnt_reg <= '0;
		end
		else
		begin
			cyc_len_reg <= (state_reg == ST_ADDR || state_reg == ST_STRB) ? cyc_len_reg + 1'b1 : '0;
			strb_cnt_reg <= strobe_on ? strb_cnt_reg + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_min_len;
		strb_end |-> cyc_len_reg + 1'b1 >= (CNT_W+2)'(BUS_MIN_CLK);
	endproperty
	a_min_len: assert property (p_min_len) else $error("bus cycle shorter than three clocks");

	property p_idle_quiet;
		state_reg == ST_IDLE |-> !strobe_on && !data_oe && !ale;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("pins active while idle");

	property p_internal;
		state_reg == ST_IDLE && req_valid && req.internal && !req_done && strap_taken_reg
			|=> req_done && !ale && !data_oe && $stable(addr_out);
	endproperty
	a_internal: assert property (p_internal) else $error("internal access touched pins");

	property p_asw_long;
		$rose(state_reg == ST_ADDR) && asw_sel_reg |-> !strobe_on ##1 !strobe_on ##1 strobe_on;
	endproperty
	a_asw_long: assert property (p_asw_long) else $error("strobe not two clocks after address");

	property p_asw_short;
		$rose(state_reg == ST_ADDR) && !asw_sel_reg |-> !strobe_on ##1 strobe_on;
	endproperty
	a_asw_short: assert property (p_asw_short) else $error("strobe not one clock after address");

	property p_auto_wait;
		strb_end && !cfg.xw |-> strb_cnt_reg + 1'b1 == (CNT_W+2)'(strb_len);
	endproperty
	a_auto_wait: assert property (p_auto_wait) else $error("strobe length differs from waits");

	property p_xwait;
		state_reg == ST_STRB && cnt_reg == '0 && cfg.xw && stall_req
			|=> strobe_on && state_reg == ST_STRB ##1 strobe_on;
	endproperty
	a_xwait: assert property (p_xwait) else $error("stall did not add two clocks");

	property p_no_ale_sep;
		!mux_mode_reg |-> !ale;
	endproperty
	a_no_ale_sep: assert property (p_no_ale_sep) else $error("latch strobe in separate mode");

	property p_ale_width;
		$rose(state_reg == ST_ADDR) && mux_mode_reg && asw_sel_reg |-> ale[*2] ##1 !ale;
	endproperty
	a_ale_width: assert property (p_ale_width) else $error("latch strobe not two clocks");

	property p_recov;
		strb_end && rec_len != '0 |=> state_reg == ST_RECOV && !strobe_on && !data_oe;
	endproperty
	a_recov: assert property (p_recov) else $error("recovery clock missing");

	c_word8: cover property (req_done && cur_reg.size == SZ_WORD && !cfg.w16);
	c_xwait: cover property (state_reg == ST_STRB && cfg.xw && stall_req);
	c_internal: cover property (state_reg == ST_IDLE && req_valid && req.internal);
	c_recov: cover property (state_reg == ST_RECOV && cfg.csr);

endmodule : embt_seq

// [embt_mem_model.sv]
// external memory device model facing the bus sequencer
`timescale 1ns/1ps
module embt_mem_model
	import embt_pkg::*;
(
	input wire logic clk,
	input wire logic mux,
	input wire logic be,
	input wire logic w16,
	input wire logic rdy_mode,
	input wire logic [7:0] stall_len,
	input wire logic [embt_pkg::ADDR_W-1:0] addr_out,
	input wire logic [embt_pkg::XD_W-1:0] data_out,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale,
	output logic [embt_pkg::XD_W-1:0] data_in,
	output logic stall_pin
);
	logic [7:0] mem [0:255];
	logic [15:0] lat_reg;
	logic [15:0] last_reg;
	logic [15:0] rd_word;
	logic [7:0] a;
	logic [7:0] ae;
	logic [7:0] ao;
	logic strb;
	logic stall_act;
	int low_cnt;

	// ==========
	// lanes and stall
	assign a = mux ? lat_reg[7:0] : addr_out[7:0];
	assign ae = {a[7:1], 1'h0};
	assign ao = {a[7:1], 1'h1};
	assign strb = (rd_n === 1'h0) || (wr_n === 1'h0);
	assign rd_word = !w16 ? {~last_reg[15:8], mem[a]} : be ? {mem[ae], mem[ao]} : {mem[ao], mem[ae]};
	// released bus shows the inverse of the last value
	assign data_in = (rd_n === 1'h0) ? rd_word : ~last_reg;
	// stall held for a set number of strobe clocks
	assign stall_act = strb && (low_cnt < stall_len);
	assign stall_pin = rdy_mode ? ~stall_act : stall_act;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h5a ^ i[7:0];
		lat_reg = 16'h0;
		last_reg = 16'h0;
		low_cnt = 0;
	end

	always @(posedge clk)
	begin
		low_cnt <= strb ? low_cnt + 1 : 0;
		if (ale === 1'h1)
			lat_reg <= data_out;
		if (rd_n === 1'h0)
			last_reg <= rd_word;
		if (wr_n === 1'h0 && !w16)
			mem[a] <= data_out[7:0];
		else if (wr_n === 1'h0)
		begin
			mem[ae] <= be ? data_out[15:8] : data_out[7:0];
			mem[ao] <= be ? data_out[7:0] : data_out[15:8];
		end
	end
endmodule : embt_mem_model

// [embt_seq_tb.sv]
// self-checking bench for the external bus sequencer
`timescale 1ns/1ps
module embt_seq_tb;
	import embt_pkg::*;

	// ==========
	// signals
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [PADDR_W-1:0] paddr = 8'h0;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic req_valid = 1'h0;
	embt_req_t req = '0;
	logic strap = 1'h0;
	logic be_m = 1'h0;
	logic w16_m = 1'h0;
	logic rdy_m = 1'h0;
	logic [7:0] stall_len = 8'h0;
	logic [DATA_W-1:0] prdata, req_rdata, rdv, d;
	logic pready, pslverr, req_done, data_oe, rd_n, wr_n, ale, stall_pin, e;
	logic [ADDR_W-1:0] addr_out;
	logic [XD_W-1:0] data_out, data_in;
	int failures = 0;
	int tests_run = 0;
	int ncyc;
	int st [5];
	localparam logic [31:0] WDAT = 32'hc3a51e69;

	embt_seq embt_seq_inst (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req(req), .req_done(req_done), .req_rdata(req_rdata),
		.bus_mode_strap(strap), .stall_pin(stall_pin), .addr_out(addr_out),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in), .rd_n(rd_n),
		.wr_n(wr_n), .ale(ale)
	);

	embt_mem_model embt_mem_model_inst (
		.clk(clk), .mux(strap), .be(be_m), .w16(w16_m), .rdy_mode(rdy_m),
		.stall_len(stall_len), .addr_out(addr_out), .data_out(data_out), .rd_n(rd_n),
		.wr_n(wr_n), .ale(ale), .data_in(data_in), .stall_pin(stall_pin)
	);

	initial
	begin
		forever
			#5 clk = ~clk;
	end

	// ==========
	// checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task automatic hang();
		failures++;
		$display("BAD t=%0t wait ran out", $time);
		end_sim();
	endtask : hang

	// ==========
	// register bus
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int i;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'h1)
				break;
		end
		if (i == 20)
			hang();
		d = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic er);
		apb(1'h0, ad, 32'h0);
		chk(d, exp, "register read");
		chk({31'h0, e}, {31'h0, er}, "read error flag");
	endtask : rchk

	// ==========
	// request port
	task automatic do_req(input logic intl, input logic wr, input logic [1:0] sz,
		input logic [1:0] blk, input logic [7:0] ad);
		logic [23:0] a0;
		int i;
		a0 = addr_out;
		st = '{default: 0};
		@(posedge clk);
		req <= '{intl, wr, sz, blk, {16'h0, ad}, WDAT};
		req_valid <= 1'h1;
		for (i = 1; i < 300; i++)
		begin
			@(posedge clk);
			if (rd_n === 1'h0 || wr_n === 1'h0)
			begin
				if (st[0] == 0)
					st[1] = i;
				st[0]++;
			end
			st[2] += (ale === 1'h1);
			st[3] += (data_oe === 1'h1);
			if (addr_out !== a0)
				st[4] = 1;
			if (req_done === 1'h1)
				break;
		end
		if (i == 300)
			hang();
		ncyc = i;
		rdv = req_rdata;
		req_valid <= 1'h0;
	endtask : do_req

	task automatic run_case(input logic asw, input logic be, input logic rdy,
		input logic [1:0] blk, input logic [9:0] cfg, input logic wr,
		input logic [1:0] sz, input logic [7:0] ad);
		logic [31:0] ev;
		logic [7:0] b8;
		logic [7:0] eb;
		int n, b, ac, w, rc, k, aw;
		n = 1 << sz;
		b = cfg[4] ? (sz == SZ_WORD ? 2 : 1) : n;
		ac = asw ? 2 : 1;
		// external wait enable lifts the automatic count to two
		aw = (cfg[3] && cfg[2:0] < 3'h2) ? 2 : int'(cfg[2:0]);
		w = aw + (cfg[3] ? 2 : 0);
		rc = wr ? cfg[8:7] : cfg[6:5];
		rc = (rc == 3 ? 2 : rc) + cfg[9];
		apb(1'h1, OFF_CTRL, {29'h0, rdy, be, asw});
		apb(1'h1, OFF_BLK0 + OFF_STEP * blk, {22'h0, cfg});
		be_m <= be;
		w16_m <= cfg[4];
		rdy_m <= rdy;
		stall_len <= cfg[3] ? 8'(3 - ac + aw) : 8'h0;
		do_req(1'h0, wr, sz, blk, ad);
		chk(ncyc, 2 + b * (3 + w + rc), "cycle count");
		chk(st[0], b * (3 - ac + w), "strobe clocks");
		chk(st[1], 2 + ac, "address to strobe");
		chk(st[2], strap ? b * ac : 0, "latch strobe clocks");
		ev = 32'h0;
		for (k = 0; k < n; k++)
		begin
			b8 = 8'h5a ^ 8'(ad + k);
			ev = be ? {ev[23:0], b8} : ev | ({24'h0, b8} << (8 * k));
			eb = WDAT[8 * (be ? n - 1 - k : k) +: 8];
			b8 = embt_mem_model_inst.mem[8'(ad + k)];
			if (wr)
				chk({24'h0, b8}, {24'h0, eb}, "stored byte");
		end
		if (!wr)
			chk(rdv, ev, "read data");
		else
			chk(rdv, 32'h0, "write returned data");
		$display("test at %h done", ad);
	endtask : run_case

	// ==========
	// main sequence
	initial
	begin
		repeat (5)
			@(posedge clk);
		rst <= 1'h0;
		rchk(OFF_CTRL, 32'h1, 1'h0);
		rchk(OFF_STAT, 32'h0, 1'h0);
		for (int i = 0; i < NBLK; i++)
			rchk(OFF_BLK0 + 8'(4 * i), 32'h0, 1'h0);
		rchk(8'h40, 32'h0, 1'h1);
		apb(1'h1, OFF_BLK0 + OFF_STEP * 2, 32'hffffffff);
		rchk(OFF_BLK0 + OFF_STEP * 2, 32'h3ff, 1'h0);
		$display("test registers done");
		run_case(1'h1, 1'h1, 1'h0, 2'h0, 10'h010, 1'h0, SZ_WORD, 8'h20);
		run_case(1'h0, 1'h0, 1'h0, 2'h1, 10'h057, 1'h0, SZ_WORD, 8'h24);
		run_case(1'h1, 1'h1, 1'h0, 2'h2, 10'h20a, 1'h0, SZ_WORD, 8'h28);
		run_case(1'h0, 1'h0, 1'h1, 2'h3, 10'h06b, 1'h0, SZ_HALF, 8'h2c);
		run_case(1'h1, 1'h0, 1'h0, 2'h0, 10'h010, 1'h0, SZ_BYTE, 8'h31);
		run_case(1'h1, 1'h1, 1'h0, 2'h0, 10'h190, 1'h1, SZ_WORD, 8'h60);
		run_case(1'h0, 1'h0, 1'h0, 2'h2, 10'h08a, 1'h1, SZ_WORD, 8'h68);
		do_req(1'h1, 1'h1, SZ_WORD, 2'h0, 8'h80);
		chk(st[0] + st[2] + st[3] + st[4], 0, "internal access moved pins");
		$display("test internal separate done");
		rst <= 1'h1;
		strap <= 1'h1;
		repeat (5)
			@(posedge clk);
		rst <= 1'h0;
		rchk(OFF_CTRL, 32'h9, 1'h0);
		run_case(1'h1, 1'h0, 1'h0, 2'h1, 10'h010, 1'h0, SZ_WORD, 8'h50);
		run_case(1'h0, 1'h1, 1'h0, 2'h3, 10'h20a, 1'h0, SZ_HALF, 8'h58);
		run_case(1'h1, 1'h0, 1'h0, 2'h0, 10'h010, 1'h1, SZ_HALF, 8'h70);
		run_case(1'h0, 1'h1, 1'h0, 2'h2, 10'h008, 1'h1, SZ_BYTE, 8'h75);
		do_req(1'h1, 1'h0, SZ_WORD, 2'h1, 8'h84);
		chk(st[0] + st[2] + st[3] + st[4], 0, "internal access moved pins");
		$display("test internal multiplexed done");
		end_sim();
	end
endmodule : embt_seq_tb
